/* File: src/sac_seq_ctrl.sv */
/*
  control registers and sequencer of a 12-bit successive
  approximation converter, apb slave with one wait state.
  assumes the analog core answers each convStart with one
  convDone pulse carrying the result, and that all trigger
  and clock source levels are synchronous to sys_clk.
*/
// The placing of the registers and the APB slave port were decided locally.
`default_nettype none
`include "sac_defs.svh"

module sac_seq_ctrl
  import sac_pkg::*;
#(
  parameter int NUM_SLOTS = 16,
  parameter int RES_W     = 12
) (
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic      [31:0]   prdata,
  output logic               pslverr,
  input  wire logic          timerAOut1,
  input  wire logic          timerBOut0,
  input  wire logic          timerBOut1,
  input  wire logic [3:0]    clkSrcLvl,
  input  wire logic          globalIrqEnable,
  input  wire logic          convDone,
  input  wire logic [RES_W-1:0] convData,
  output logic               samplingControl,
  output logic               convStart,
  output logic               convClkTick,
  output sac_core_ctl_t      coreCtl,
  output logic               irqRequest
);

  ////////////////////////////////////////////////////////////////
  // elaboration checks
  generate
    if (NUM_SLOTS != 16 || RES_W != 12) begin : g_bad
      $error("slot count must be 16 and result width 12");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // sample length lookup, code 1100 and above saturate
  function automatic logic [`SAC_SHT_W-1:0] shtCycles(
    input logic [3:0] code);
    logic [4:0]  idx;
    logic [142:0] tbl;
    tbl = `SAC_SHT_TABLE;
    idx = (code >= `SAC_SHT_LAST) ? {1'b0, `SAC_SHT_LAST}
                                  : {1'b0, code};
    return tbl[idx*`SAC_SHT_W +: `SAC_SHT_W];
  endfunction

  ////////////////////////////////////////////////////////////////
  // state
  sac_ctl0_t       ctl0_reg, ctl0_next;
  sac_ctl1_t       ctl1_reg, ctl1_next;
  sac_slot_ctl_t   slotCtl_reg [16];
  logic [RES_W-1:0] result_reg [16];
  logic [15:0]     flags_reg, flags_next;
  logic [15:0]     irqEn_reg;
  logic            ovCond_reg, ovCond_next;
  logic            tovCond_reg, tovCond_next;
  logic            swPulse_reg;
  logic            shiPrev_reg;
  logic [3:0]      srcPrev_reg;
  logic [2:0]      divCnt_reg;
  logic [`SAC_SHT_W-1:0] sampCnt_reg, sampCnt_next;
  logic [3:0]      slot_reg, slot_next;
  sac_state_t      state_reg, state_next;
  logic            storeStrobe;

  ////////////////////////////////////////////////////////////////
  // apb decode, one wait state on every access
  logic        accPhase, access, wrAcc, rdAcc;
  logic        isCtl0, isCtl1, isFlags, isIe, isVec;
  logic        isResult, isSlotCtl, mapped;
  logic [3:0]  regIdx;

  assign accPhase  = psel & penable;
  assign access    = accPhase & pready;
  assign wrAcc     = access & pwrite;
  assign rdAcc     = access & ~pwrite;
  assign regIdx    = paddr[5:2];
  assign isCtl0    = paddr == `SAC_OFF_CTL0;
  assign isCtl1    = paddr == `SAC_OFF_CTL1;
  assign isFlags   = paddr == `SAC_OFF_FLAGS;
  assign isIe      = paddr == `SAC_OFF_IE;
  assign isVec     = paddr == `SAC_OFF_VECTOR;
  assign isResult  = paddr[11:6] == `SAC_OFF_RESULT
                   && paddr[1:0] == 2'h0;
  assign isSlotCtl = paddr[11:6] == `SAC_OFF_SLOTCTL
                   && paddr[1:0] == 2'h0;
  assign mapped    = isCtl0 | isCtl1 | isFlags | isIe | isVec
                   | isResult | isSlotCtl;

  ////////////////////////////////////////////////////////////////
  // trigger path: source select, invert, edge
  logic trigRaw, sampleInput, shiRise;
  logic conversion_enable;

  assign conversion_enable = ctl0_reg.conversionEnable;
  always_comb begin
    unique case (ctl1_reg.triggerSourceSelect)
      2'b00: trigRaw = swPulse_reg;
      2'b01: trigRaw = timerAOut1;
      2'b10: trigRaw = timerBOut0;
      2'b11: trigRaw = timerBOut1;
    endcase
  end
  assign sampleInput = trigRaw ^ ctl1_reg.triggerInvert;
  assign shiRise     = sampleInput & ~shiPrev_reg;

  ////////////////////////////////////////////////////////////////
  // conversion clock: selected source edge, divided
  logic srcEdge, tick;
  logic [1:0] srcSel;

  assign srcSel  = ctl1_reg.convClockSource;
  assign srcEdge = clkSrcLvl[srcSel] & ~srcPrev_reg[srcSel];
  assign tick    = srcEdge
                 && divCnt_reg == ctl1_reg.convClockDivider;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      srcPrev_reg <= 4'h0;
      divCnt_reg  <= 3'h0;
      shiPrev_reg <= 1'b0;
    end else begin
      srcPrev_reg <= clkSrcLvl;
      shiPrev_reg <= sampleInput;
      if (tick)
        divCnt_reg <= 3'h0;
      else if (srcEdge)
        divCnt_reg <= divCnt_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sequencer
  sac_mode_t     mode;
  sac_slot_ctl_t curCtl;
  logic [3:0]    shtCode, nextSlot;
  logic          last_in_sequence, chain, repeatMode, sampleDone;

  assign mode     = sac_mode_t'(ctl1_reg.sequenceMode);
  assign curCtl   = slotCtl_reg[slot_reg];
  assign last_in_sequence      = curCtl.lastInSequence;
  assign repeatMode = mode[1];
  // slots 8-15 use the upper time, 0-7 the lower
  assign shtCode  = slot_reg[3] ? ctl0_reg.upperSampleTime
                                : ctl0_reg.lowerSampleTime;
  assign chain    = ctl0_reg.multiConvertBit
                  && mode != SAC_SINGLE;
  // the count is loaded with the full table length and ends one tick past zero,
  // so a partial first tick never shortens the sample
  assign sampleDone = ctl1_reg.pulseModeSelect
                    ? (tick && sampCnt_reg == '0)
                    : ~sampleInput;
  assign storeStrobe = state_reg == SAC_CONV && convDone;

  always_comb begin
    state_next   = state_reg;
    slot_next    = slot_reg;
    sampCnt_next = sampCnt_reg;
    nextSlot     = slot_reg;
    if (state_reg == SAC_SAMPLE && tick && sampCnt_reg != '0)
      sampCnt_next = sampCnt_reg - 1'b1;
    unique case (state_reg)
      SAC_IDLE: begin
        // needs enable and power before a start from idle
        if (conversion_enable && ctl0_reg.converterPowerOn && shiRise) begin
          state_next   = SAC_SAMPLE;
          slot_next    = ctl1_reg.startSlotIndex;
          // the first slot, not the last one used, sets the length
          sampCnt_next = shtCycles(ctl1_reg.startSlotIndex[3]
                       ? ctl0_reg.upperSampleTime
                       : ctl0_reg.lowerSampleTime);
        end
      end
      SAC_SAMPLE: begin
        if (sampleDone)
          state_next = SAC_CONV;
      end
      SAC_CONV: begin
        if (convDone) begin
          // next slot: same, next one, or back to start
          if (mode == SAC_REPEAT_ONE)
            nextSlot = slot_reg;
          else if (last_in_sequence)
            nextSlot = ctl1_reg.startSlotIndex;
          else
            nextSlot = slot_reg + 4'h1;
          slot_next = nextSlot;
          if (mode == SAC_SINGLE || (mode == SAC_SEQUENCE && last_in_sequence))
            state_next = SAC_IDLE;
          else if (repeatMode && !conversion_enable)
            state_next = SAC_IDLE;
          else if (chain) begin
            state_next   = SAC_SAMPLE;
            sampCnt_next = shtCycles(nextSlot[3]
                         ? ctl0_reg.upperSampleTime
                         : ctl0_reg.lowerSampleTime);
          end else
            state_next = SAC_WAIT;
        end
      end
      SAC_WAIT: begin
        if (!conversion_enable)
          state_next = SAC_IDLE;
        else if (shiRise) begin
          state_next   = SAC_SAMPLE;
          sampCnt_next = shtCycles(shtCode);
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg   <= SAC_IDLE;
      slot_reg    <= 4'h0;
      sampCnt_reg <= '0;
    end else begin
      state_reg   <= state_next;
      slot_reg    <= slot_next;
      sampCnt_reg <= sampCnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // control register writes, guarded fields frozen while enabled
  logic [15:0] wd16, lock0, lock1;

  assign wd16  = pwdata[15:0];
  assign lock0 = conversion_enable ? `SAC_CTL0_LOCKED : 16'h0000;
  assign lock1 = conversion_enable ? `SAC_CTL1_LOCKED : 16'h0000;

  always_comb begin
    ctl0_next = ctl0_reg;
    ctl1_next = ctl1_reg;
    if (wrAcc && isCtl0)
      ctl0_next = sac_ctl0_t'((ctl0_reg & lock0)
                | (wd16 & ~lock0 & `SAC_CTL0_WMASK));
    if (wrAcc && isCtl1)
      ctl1_next = sac_ctl1_t'((ctl1_reg & lock1)
                | (wd16 & ~lock1));
    ctl1_next.converterBusy = state_next != SAC_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl0_reg    <= sac_ctl0_t'(`SAC_CTL0_RST);
      ctl1_reg    <= sac_ctl1_t'(`SAC_CTL1_RST);
      irqEn_reg   <= `SAC_IE_RST;
      swPulse_reg <= 1'b0;
    end else begin
      ctl0_reg    <= ctl0_next;
      ctl1_reg    <= ctl1_next;
      // start bit never stored, seen as one cycle pulse
      swPulse_reg <= wrAcc && isCtl0 && wd16[0]
                  && ctl0_next.conversionEnable;
      if (wrAcc && isIe)
        irqEn_reg <= wd16;
    end
  end

  ////////////////////////////////////////////////////////////////
  // slot control bytes and result slots
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_slot
      always_ff @(posedge sys_clk) begin
        if (sys_rst)
          slotCtl_reg[gi] <= sac_slot_ctl_t'(`SAC_SLOTCTL_RST);
        else if (wrAcc && isSlotCtl && regIdx == gi && !conversion_enable)
          slotCtl_reg[gi] <= sac_slot_ctl_t'(
                             pwdata[`SAC_SLOTCTL_W-1:0]);
      end
      // results keep their value over reset
      always_ff @(posedge sys_clk) begin
        if (storeStrobe && slot_reg == gi)
          result_reg[gi] <= convData;
        else if (wrAcc && isResult && regIdx == gi)
          result_reg[gi] <= pwdata[RES_W-1:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // flags and overflow conditions, hardware set wins
  logic [15:0] setVec, clrVec;
  logic [5:0]  vecWord;
  logic        vecAccess;

  assign setVec    = storeStrobe ? (16'h0001 << slot_reg) : 16'h0000;
  assign clrVec    = (access && isResult) ? (16'h0001 << regIdx)
                                          : 16'h0000;
  assign vecAccess = access & isVec;

  always_comb begin
    flags_next = flags_reg & ~clrVec;
    if (wrAcc && isFlags)
      flags_next = wd16;
    flags_next = flags_next | setVec;
    ovCond_next = ovCond_reg;
    if (vecAccess && vecWord == `SAC_VEC_OVERWRITE)
      ovCond_next = 1'b0;
    if (storeStrobe && flags_reg[slot_reg])
      ovCond_next = 1'b1;
    tovCond_next = tovCond_reg;
    if (vecAccess && vecWord == `SAC_VEC_TIMING)
      tovCond_next = 1'b0;
    if (shiRise && (state_reg == SAC_SAMPLE || state_reg == SAC_CONV))
      tovCond_next = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_reg   <= 16'h0000;
      ovCond_reg  <= 1'b0;
      tovCond_reg <= 1'b0;
    end else begin
      flags_reg   <= flags_next;
      ovCond_reg  <= ovCond_next;
      tovCond_reg <= tovCond_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // vector: overwrite, then timing, then slot 0 upward
  logic [15:0] slotPend;

  assign slotPend = flags_reg & irqEn_reg;
  always_comb begin
    vecWord = `SAC_VEC_NONE;
    for (int i = 15; i >= 0; i--) begin
      if (slotPend[i])
        vecWord = `SAC_VEC_SLOT0 + 6'(2 * i);
    end
    if (tovCond_reg && ctl0_reg.timingOverflowIrqEnable)
      vecWord = `SAC_VEC_TIMING;
    if (ovCond_reg && ctl0_reg.overwriteIrqEnable)
      vecWord = `SAC_VEC_OVERWRITE;
  end

  ////////////////////////////////////////////////////////////////
  // read mux
  logic [15:0] rdMux;

  always_comb begin
    rdMux = 16'h0000;
    if (isCtl0)
      rdMux = ctl0_reg;
    else if (isCtl1)
      rdMux = ctl1_reg;
    else if (isFlags)
      rdMux = flags_reg;
    else if (isIe)
      rdMux = irqEn_reg;
    else if (isVec)
      rdMux = {10'h000, vecWord};
    else if (isResult)
      rdMux = {4'h0, result_reg[regIdx]};
    else if (isSlotCtl)
      rdMux = {8'h00, slotCtl_reg[regIdx]};
  end

  ////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready          <= 1'b0;
      prdata          <= 32'h0000_0000;
      pslverr         <= 1'b0;
      samplingControl <= 1'b0;
      convStart       <= 1'b0;
      convClkTick     <= 1'b0;
      coreCtl         <= '0;
      irqRequest      <= 1'b0;
    end else begin
      pready  <= accPhase & ~pready;
      pslverr <= accPhase & ~pready & ~mapped;
      if (accPhase && !pready && !pwrite)
        prdata <= {16'h0000, rdMux};
      samplingControl <= state_next == SAC_SAMPLE;
      convStart <= state_reg == SAC_SAMPLE
                && state_next == SAC_CONV;
      convClkTick <= tick;
      coreCtl.converterPowerOn <= ctl0_reg.converterPowerOn;
      coreCtl.refPowerOn <= ctl0_reg.refPowerOn;
      coreCtl.refLevelSelect <= ctl0_reg.refPowerOn
                             & ctl0_reg.refLevelSelect;
      coreCtl.referenceSelect <= slotCtl_reg[slot_next].referenceSelect;
      coreCtl.inputChannelSelect <=
        slotCtl_reg[slot_next].inputChannelSelect;
      irqRequest <= globalIrqEnable
                 && vecWord != `SAC_VEC_NONE;
    end
  end

endmodule

`default_nettype wire

/* File: src/sac_defs.svh */
/*
  register offsets, field masks and timing constants of the
  converter sequencer.
  assumes inclusion by bare name from the design files.
*/
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// apb byte offsets; result and slot control as paddr[11:6] block numbers
`define SAC_OFF_CTL0      12'h000
`define SAC_OFF_CTL1      12'h004
`define SAC_OFF_FLAGS     12'h008
`define SAC_OFF_IE        12'h00C
`define SAC_OFF_VECTOR    12'h010
`define SAC_OFF_RESULT    6'h01
`define SAC_OFF_SLOTCTL   6'h02

// writable bits guarded by the conversion enable bit
`define SAC_CTL0_LOCKED   16'hFFE0
`define SAC_CTL0_WMASK    16'hFFFE
`define SAC_CTL1_LOCKED   16'hFFFE
`define SAC_SLOTCTL_W     8

// reset values
`define SAC_CTL0_RST      16'h0000
`define SAC_CTL1_RST      16'h0000
`define SAC_SLOTCTL_RST   8'h00
`define SAC_IE_RST        16'h0000

// vector codes
`define SAC_VEC_NONE      6'h00
`define SAC_VEC_OVERWRITE 6'h02
`define SAC_VEC_TIMING    6'h04
`define SAC_VEC_SLOT0     6'h06

// sample lengths in conversion clocks, code 0 in the low slice
`define SAC_SHT_W         11
`define SAC_SHT_LAST      4'hC
`define SAC_SHT_TABLE {11'h400, 11'h300, 11'h200, 11'h180, 11'h100, \
  11'h0C0, 11'h080, 11'h060, 11'h040, 11'h020, 11'h010, 11'h008, 11'h004}

`endif

/* File: src/sac_pkg.sv */
/*
  types of the converter sequencer: register layouts, slot
  control byte, core control bundle and sequencer states.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none

package sac_pkg;

  typedef struct packed {
    logic [3:0] upperSampleTime;
    logic [3:0] lowerSampleTime;
    logic       multiConvertBit;
    logic       refLevelSelect;
    logic       refPowerOn;
    logic       converterPowerOn;
    logic       overwriteIrqEnable;
    logic       timingOverflowIrqEnable;
    logic       conversionEnable;
    logic       softwareStart;
  } sac_ctl0_t;

  typedef struct packed {
    logic [3:0] startSlotIndex;
    logic [1:0] triggerSourceSelect;
    logic       pulseModeSelect;
    logic       triggerInvert;
    logic [2:0] convClockDivider;
    logic [1:0] convClockSource;
    logic [1:0] sequenceMode;
    logic       converterBusy;
  } sac_ctl1_t;

  typedef struct packed {
    logic       lastInSequence;
    logic [2:0] referenceSelect;
    logic [3:0] inputChannelSelect;
  } sac_slot_ctl_t;

  // analog side controls, all held in flip-flops
  typedef struct packed {
    logic       converterPowerOn;
    logic       refPowerOn;
    logic       refLevelSelect;
    logic [2:0] referenceSelect;
    logic [3:0] inputChannelSelect;
  } sac_core_ctl_t;

  typedef enum logic [1:0] {
    SAC_IDLE   = 2'b00,
    SAC_SAMPLE = 2'b01,
    SAC_CONV   = 2'b10,
    SAC_WAIT   = 2'b11
  } sac_state_t;

  typedef enum logic [1:0] {
    SAC_SINGLE     = 2'b00,
    SAC_SEQUENCE   = 2'b01,
    SAC_REPEAT_ONE = 2'b10,
    SAC_REPEAT_SEQ = 2'b11
  } sac_mode_t;

endpackage

`default_nettype wire

/* File: sim/sac_seq_ctrl_properties.sv */
/*
  concurrent checks on the top ports of the converter sequencer.
  assumes the bind below and one clock domain on sys_clk.
*/
`default_nettype none

module sac_seq_ctrl_props
  import sac_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          sys_rst,
  input wire logic          pready,
  input wire logic [31:0]   prdata,
  input wire logic          globalIrqEnable,
  input wire logic          samplingControl,
  input wire logic          convStart,
  input wire logic          convClkTick,
  input wire sac_core_ctl_t coreCtl,
  input wire logic          irqRequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // core link and request relations
  a_ref_level_gated:
    assert property (!coreCtl.refPowerOn |-> !coreCtl.refLevelSelect)
    else $error("reference level active while reference off");
  a_irq_needs_gie:
    assert property (!$past(globalIrqEnable) |-> !irqRequest)
    else $error("request raised without global enable");
  a_conv_needs_power:
    assert property (convStart |-> coreCtl.converterPowerOn)
    else $error("conversion started with core unpowered");
  a_start_after_sample:
    assert property ($fell(samplingControl) |-> convStart)
    else $error("no conversion start as sampling ended");
  a_no_start_sampling:
    assert property (samplingControl |-> !convStart)
    else $error("conversion start while sampling");
  a_start_one_cycle:
    assert property (convStart |=> !convStart)
    else $error("conversion start longer than one cycle");
  a_read_top_zero:
    assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_tick_spacing:
    assert property (convClkTick |=> !convClkTick)
    else $error("conversion ticks closer than a source period");
endmodule

bind sac_seq_ctrl sac_seq_ctrl_props u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .pready(pready), .prdata(prdata),
  .globalIrqEnable(globalIrqEnable), .samplingControl(samplingControl),
  .convStart(convStart), .convClkTick(convClkTick), .coreCtl(coreCtl),
  .irqRequest(irqRequest));

`default_nettype wire

/* File: sim/sac_core_model.sv */
/*
  behavioural analog core: answers each convStart with one convDone.
  assumes convStart is a one-cycle pulse on sys_clk.
*/
`default_nettype none

module sac_core_model
  import sac_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic          convStart,
  input  wire sac_core_ctl_t coreCtl,
  output logic               convDone,
  output logic [11:0]        convData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  busyCnt_reg;
  logic [11:0] result_reg;

  // odd channels answer slowly; data line toggles outside the pulse
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busyCnt_reg <= 3'h0;
      convDone    <= 1'b0;
      convData    <= 12'h000;
    end else begin
      convDone <= busyCnt_reg == 3'h1;
      convData <= (busyCnt_reg == 3'h1) ? result_reg : ~convData;
      if (convStart) begin
        busyCnt_reg <= coreCtl.inputChannelSelect[0] ? 3'h5 : 3'h2;
        result_reg <= {1'b0, coreCtl.referenceSelect, 4'h0,
                       coreCtl.inputChannelSelect};
      end else if (busyCnt_reg != 3'h0)
        busyCnt_reg <= busyCnt_reg - 3'h1;
    end
  end
endmodule

`default_nettype wire

/* File: sim/tb_sac_seq_ctrl.sv */
/*
  self-checking bench of the converter sequencer over apb.
  assumes the core model and the bound property checker.
*/
`default_nettype none
`include "sac_defs.svh"

module tb_sac_seq_ctrl
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          sys_clk = 0, sys_rst = 1, psel = 0, penable = 0;
  logic          pwrite = 0, pready, pslverr, convDone, err;
  logic [11:0]   paddr = 0, convData;
  logic [31:0]   pwdata = 0, prdata, rd, seed = 32'h8DB1;
  logic [2:0]    tmr = 0;
  logic [3:0]    clkSrcLvl = 0;
  logic          globalIrqEnable = 0, samplingControl, convStart;
  logic          convClkTick, irqRequest;
  sac_core_ctl_t coreCtl;
  int            fails = 0, compares = 0, sLen = 0, lastLen = 0;

  sac_seq_ctrl u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timerAOut1(tmr[0]), .timerBOut0(tmr[1]), .timerBOut1(tmr[2]),
    .clkSrcLvl(clkSrcLvl), .globalIrqEnable(globalIrqEnable),
    .convDone(convDone), .convData(convData),
    .samplingControl(samplingControl), .convStart(convStart),
    .convClkTick(convClkTick), .coreCtl(coreCtl), .irqRequest(irqRequest));
  sac_core_model u_core (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .convStart(convStart), .coreCtl(coreCtl), .convDone(convDone),
    .convData(convData));

  ////////////////////////////////////////////////////////////////////////
  // clock, source clocks and sampling length meter
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    clkSrcLvl <= clkSrcLvl + 4'h1;
    if (samplingControl === 1'b1) sLen <= sLen + 1;
    else if (sLen != 0) begin
      lastLen <= sLen;
      sLen <= 0;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic int ticks(input logic [3:0] c);
    int t[12] = '{4, 8, 16, 32, 64, 96, 128, 192, 256, 384, 512, 768};
    return (c > 4'hB) ? 1024 : t[c];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 5000; n++) begin
      apb(0, `SAC_OFF_CTL1, 0);
      if (rd[0] === 1'b0) break;
    end
    chk(rd[0], 0);
  endtask
  task automatic stop_test();
    $display("counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one software-started conversion into a chosen slot
  task automatic conv(input logic [3:0] s, input logic [3:0] c,
                      input logic [2:0] dv);
    logic [7:0] b;
    logic [3:0] up, lo;
    int p;
    seed = xs(seed);
    b = {1'b0, seed[6:0]};
    up = s[3] ? c : 4'hF;
    lo = s[3] ? 4'hF : c;
    p = (s[0] ? 4 : 2) * (dv + 1);
    apb(1, `SAC_OFF_CTL0, 0);
    apb(1, 12'h080 + 4 * s, b);
    apb(1, `SAC_OFF_CTL1, {s, 4'b0010, dv, 1'b0, s[0], 3'h0});
    apb(1, `SAC_OFF_CTL0, {up, lo, 8'h13});
    apb(1, `SAC_OFF_CTL0, 32'h13);
    apb(0, `SAC_OFF_CTL0, 0);
    chk(rd, {up, lo, 8'h12});
    wait_idle();
    chk(lastLen >= ticks(c) * p && lastLen <= (ticks(c) + 1) * p + 2, 1);
    apb(0, `SAC_OFF_FLAGS, 0);
    chk(rd[s], 1);
    apb(0, 12'h040 + 4 * s, 0);
    chk(rd, {21'h0, b[6:4], 4'h0, b[3:0]});
    apb(0, `SAC_OFF_FLAGS, 0);
    chk(rd[s], 0);
  endtask

  initial begin
    #(8 * 60000);
    fails++;
    stop_test();
  end

  initial begin
    logic [3:0] sl[4] = '{4'h3, 4'hC, 4'h7, 4'h9};
    logic [3:0] cd[4] = '{4'h0, 4'h5, 4'hB, 4'hC};
    logic [2:0] dd[4] = '{3'h0, 3'h7, 3'h3, 3'h0};
    logic [11:0] ra[4] = '{`SAC_OFF_CTL0, `SAC_OFF_CTL1, `SAC_OFF_IE,
                           12'h0BC};
    int h;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk(rd, 0);
    end
    apb(0, 12'h0FC, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 0);
    $display("test reset and map done");
    foreach (sl[i]) conv(sl[i], cd[i], dd[i]);
    $display("test single conversions done");
    apb(1, `SAC_OFF_CTL0, 0);
    apb(1, 12'h090, 32'h01);
    apb(1, 12'h094, 32'h02);
    apb(1, 12'h098, 32'h83);
    apb(1, `SAC_OFF_CTL1, {4'h4, 4'b0010, 8'h02});
    apb(1, `SAC_OFF_CTL0, 32'h0F93);
    wait_idle();
    apb(0, `SAC_OFF_FLAGS, 0);
    chk(rd[15:0], 16'h0070);
    $display("test sequence done");
    apb(1, `SAC_OFF_IE, 32'h20);
    globalIrqEnable <= 1'b1;
    apb(0, `SAC_OFF_VECTOR, 0);
    chk(rd, 32'h10);
    chk(irqRequest, 1);
    globalIrqEnable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(irqRequest, 0);
    apb(0, 12'h054, 0);
    chk(rd, 32'h2);
    apb(0, `SAC_OFF_VECTOR, 0);
    chk(rd, 0);
    $display("test interrupt gating done");
    for (int t = 0; t < 3; t++) begin
      apb(1, `SAC_OFF_CTL0, 0);
      apb(1, `SAC_OFF_CTL1, {4'h0, 2'(t + 1), 2'b10, 8'h00});
      apb(1, `SAC_OFF_CTL0, 32'h12);
      tmr <= 3'(1 << t);
      for (int n = 0; n < 20 && samplingControl !== 1'b1; n++)
        @(posedge sys_clk);
      chk(samplingControl, 1);
      tmr <= 3'h0;
      wait_idle();
      apb(0, 12'h040, 0);
      chk(rd, 0);
    end
    $display("test timer triggers done");
    // direct mode, inverted timer input, into slot 4 whose flag is set
    seed = xs(seed);
    h = 3 + seed[4:0];
    apb(1, `SAC_OFF_CTL0, 0);
    apb(1, `SAC_OFF_CTL1, 32'h4500);
    apb(1, `SAC_OFF_CTL0, 32'h1A);
    tmr <= 3'h1;
    @(posedge sys_clk);
    tmr <= 3'h0;
    repeat (h) @(posedge sys_clk);
    tmr <= 3'h1;
    wait_idle();
    chk(lastLen, h);
    apb(0, `SAC_OFF_VECTOR, 0);
    chk(rd, 32'h2);
    apb(0, `SAC_OFF_VECTOR, 0);
    chk(rd, 0);
    $display("test direct mode and overflow done");
    stop_test();
  end
endmodule

`default_nettype wire
